/* hdl/sarts_params.svh */
// register map, field positions and timing figures of the sar trigger sequencer
`ifndef SARTS_PARAMS_SVH
`define SARTS_PARAMS_SVH

`define SARTS_ADDR_MODE 8'h00
`define SARTS_ADDR_CHSEL 8'h04
`define SARTS_ADDR_RES_A 8'h08
`define SARTS_ADDR_RES_B 8'h0c
`define SARTS_ADDR_CMP_A 8'h10
`define SARTS_ADDR_CMP_B 8'h14
`define SARTS_ADDR_STATUS 8'h18

`define SARTS_MODE_CMP_EN 0
`define SARTS_MODE_OPM_LO 1
`define SARTS_MODE_OPM_HI 2
`define SARTS_MODE_TSEL_LO 3
`define SARTS_MODE_TSEL_HI 5
`define SARTS_MODE_RUN 7
`define SARTS_MODE_MASK 8'hbf

`define SARTS_CH_LO 0
`define SARTS_CH_HI 3
`define SARTS_CH_TRIG_A 4
`define SARTS_CH_TRIG_B 5

`define SARTS_STAT_BUSY 0
`define SARTS_STAT_ARMED 1
`define SARTS_STAT_SAR_LO 16

`define SARTS_RST_MODE 8'h00
`define SARTS_RST_CHSEL 6'h00
`define SARTS_RST_CMP 16'h0000
`define SARTS_RST_RES 10'h000

`define SARTS_CLK_MHZ 20
`define SARTS_SAMPLE_NS 1000
`define SARTS_STEP_NS 250

`endif

/* hdl/sarts_pkg.sv */
// types shared by the sar trigger sequencer modules
package sarts_pkg;

  typedef enum logic [2:0] {
    SARTS_IDLE = 3'h0,
    SARTS_WAIT = 3'h1,
    SARTS_SAMPLE = 3'h3,
    SARTS_TRIAL = 3'h2,
    SARTS_LATCH = 3'h6
  } sarts_state_t;

  typedef struct packed {
    logic cmpEnable;
    logic [1:0] opMode;
    logic [3:0] channel;
    logic sampleOn;
    logic holdOn;
    logic [9:0] dacCode;
  } sarts_afe_t;

  typedef struct packed {
    logic prev;
    logic trig;
  } sarts_trig_t;

  typedef struct packed {
    sarts_state_t st;
    logic [7:0] modeReg;
    logic [5:0] chReg;
    logic [15:0] cmpA;
    logic [15:0] cmpB;
    logic [9:0] resA;
    logic [9:0] resB;
    logic [9:0] approx;
    logic [3:0] bitIdx;
    logic [7:0] cnt;
    logic tgtB;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    sarts_afe_t afe;
  } sarts_regs_t;

endpackage

/* hdl/sarts_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sarts_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sarts_sync_t;

  sarts_sync_t r;
  sarts_sync_t next_r;

  always_comb begin
    next_r.s1 = din;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign dout = r.s2;
endmodule

/* hdl/sarts_trig_gen.sv */
// compare-zero match trigger of one pwm timer
`timescale 1ns/100ps
module sarts_trig_gen
  import sarts_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [CW-1:0] timerCount,
  input wire logic [CW-1:0] compareZero,
  output logic trig
);
  sarts_trig_t r;
  sarts_trig_t next_r;
  logic match;

  always_comb begin
    match = (timerCount == compareZero);
    next_r.prev = match;
    // one pulse per match, however long the counter rests on the value
    next_r.trig = match && !r.prev;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign trig = r.trig;
endmodule

/* hdl/sarts_top.sv */
// sar converter sequencer in timer trigger mode, with apb registers
// Notes on behaviour
// - mode bit 0 written 1 enables the voltage comparator
// - channel register bits 4 and 5 pick timer a or timer b as trigger
// - channel register selects exactly one input channel converted per trigger
// - run bit 7 arms the converter into trigger wait, no immediate conversion
// - while armed, a pulse from the selected timer starts a conversion
// - each timer makes its trigger from a compare-zero match
// - sample the input for a fixed period, then hold until conversion ends
// - first step sets bit 9, generator at half reference
// - msb stays 1 if input at or above half reference, else cleared
// - second step sets bit 8, generator at three or one quarter
// - each trial keeps bit if input at least generator output, else clears
// - trials run one bit per step down to bit 0
// - ten-bit result latched into the selected timer's result register
// - each latched result raises the conversion-done interrupt request
// - repeat per trigger while run stays 1; stop when cleared
`timescale 1ns/100ps
`include "sarts_params.svh"
module sarts_top
  import sarts_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CW-1:0] timerCountA,
  input wire logic [CW-1:0] timerCountB,
  input wire logic cmpAbove,
  output sarts_afe_t afeCtrl,
  output logic conversion_done_irq
);
  // least times round up to whole cycles
  localparam int SampleCycles = (`SARTS_SAMPLE_NS * `SARTS_CLK_MHZ + 999) / 1000;
  localparam int StepCycles = (`SARTS_STEP_NS * `SARTS_CLK_MHZ + 999) / 1000;

  sarts_regs_t r;
  sarts_regs_t next_r;
  logic trigA;
  logic trigB;
  logic cmpSync;
  logic wrEn;
  logic rdEn;
  logic mapped;
  logic [31:0] rdData;
  logic runNext;
  logic trigHit;
  logic [7:0] stepLen;
  logic [9:0] bitMask;

  sarts_trig_gen #(.CW(CW)) u_trig_a (
    .clk(clk),
    .sys_rst(sys_rst),
    .timerCount(timerCountA),
    .compareZero(r.cmpA),
    .trig(trigA)
  );

  sarts_trig_gen #(.CW(CW)) u_trig_b (
    .clk(clk),
    .sys_rst(sys_rst),
    .timerCount(timerCountB),
    .compareZero(r.cmpB),
    .trig(trigB)
  );

  // comparator output is analog-side and asynchronous
  sarts_sync #(.WIDTH(1)) u_cmp_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(cmpAbove),
    .dout(cmpSync)
  );

  always_comb begin
    next_r = r;
    wrEn = psel && penable && r.pready && pwrite;
    rdEn = psel && penable && !r.pready;
    mapped = 1'b1;
    rdData = 32'h0000_0000;
    case (paddr)
      `SARTS_ADDR_MODE: begin
        rdData = {24'h00_0000, r.modeReg};
      end
      `SARTS_ADDR_CHSEL: begin
        rdData = {26'h000_0000, r.chReg};
      end
      `SARTS_ADDR_RES_A: begin
        rdData = {22'h00_0000, r.resA};
      end
      `SARTS_ADDR_RES_B: begin
        rdData = {22'h00_0000, r.resB};
      end
      `SARTS_ADDR_CMP_A: begin
        rdData = {16'h0000, r.cmpA};
      end
      `SARTS_ADDR_CMP_B: begin
        rdData = {16'h0000, r.cmpB};
      end
      `SARTS_ADDR_STATUS: begin
        rdData[`SARTS_STAT_BUSY] = (r.st != SARTS_IDLE) && (r.st != SARTS_WAIT);
        rdData[`SARTS_STAT_ARMED] = (r.st != SARTS_IDLE);
        rdData[`SARTS_STAT_SAR_LO +: 10] = r.approx;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase

    // one wait state: ready is high in the second access cycle, low after
    next_r.pready = rdEn;
    next_r.pslverr = rdEn && !mapped;
    next_r.prdata = (rdEn && !pwrite) ? rdData : 32'h0000_0000;

    if (wrEn && mapped) begin
      case (paddr)
        `SARTS_ADDR_MODE: begin
          next_r.modeReg = pwdata[7:0] & `SARTS_MODE_MASK;
        end
        `SARTS_ADDR_CHSEL: begin
          next_r.chReg = pwdata[5:0];
        end
        `SARTS_ADDR_CMP_A: begin
          next_r.cmpA = pwdata[15:0];
        end
        `SARTS_ADDR_CMP_B: begin
          next_r.cmpB = pwdata[15:0];
        end
        default: begin
        end
      endcase
    end

    runNext = next_r.modeReg[`SARTS_MODE_RUN];
    // conversion time selection stretches each trial step
    stepLen = 8'(StepCycles) * (8'(r.modeReg[`SARTS_MODE_TSEL_HI:`SARTS_MODE_TSEL_LO]) + 8'h01);
    bitMask = 10'h001 << r.bitIdx;
    trigHit = 1'b0;
    if (r.chReg[`SARTS_CH_TRIG_B:`SARTS_CH_TRIG_A] == 2'b01) begin
      trigHit = trigA;
    end else if (r.chReg[`SARTS_CH_TRIG_B:`SARTS_CH_TRIG_A] == 2'b10) begin
      trigHit = trigB;
    end
    next_r.irq = 1'b0;

    case (r.st)
      SARTS_IDLE: begin
        if (runNext) begin
          next_r.st = SARTS_WAIT;
        end
      end
      SARTS_WAIT: begin
        if (trigHit) begin
          next_r.st = SARTS_SAMPLE;
          next_r.tgtB = r.chReg[`SARTS_CH_TRIG_B];
          next_r.cnt = 8'(SampleCycles - 1);
          next_r.approx = 10'h000;
        end
      end
      SARTS_SAMPLE: begin
        if (r.cnt == 8'h00) begin
          // hold starts, msb under trial at half reference
          next_r.st = SARTS_TRIAL;
          next_r.bitIdx = 4'h9;
          next_r.approx = 10'h200;
          next_r.cnt = stepLen - 8'h01;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      SARTS_TRIAL: begin
        if (r.cnt == 8'h00) begin
          // keep bit when input at or above generator output
          if (!cmpSync) begin
            next_r.approx = r.approx & ~bitMask;
          end
          if (r.bitIdx == 4'h0) begin
            next_r.st = SARTS_LATCH;
          end else begin
            next_r.bitIdx = r.bitIdx - 4'h1;
            next_r.approx = (cmpSync ? r.approx : (r.approx & ~bitMask)) | (bitMask >> 1);
            next_r.cnt = stepLen - 8'h01;
          end
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      SARTS_LATCH: begin
        if (r.tgtB) begin
          next_r.resB = r.approx;
        end else begin
          next_r.resA = r.approx;
        end
        next_r.irq = 1'b1;
        next_r.st = SARTS_WAIT;
      end
      default: begin
        next_r.st = SARTS_IDLE;
      end
    endcase

    // clearing run wins over every state, the current result is dropped
    if (!runNext) begin
      next_r.st = SARTS_IDLE;
      next_r.irq = 1'b0;
      next_r.resA = (r.st == SARTS_LATCH) ? r.resA : next_r.resA;
      next_r.resB = (r.st == SARTS_LATCH) ? r.resB : next_r.resB;
    end

    next_r.afe.cmpEnable = next_r.modeReg[`SARTS_MODE_CMP_EN];
    next_r.afe.opMode = next_r.modeReg[`SARTS_MODE_OPM_HI:`SARTS_MODE_OPM_LO];
    next_r.afe.channel = next_r.chReg[`SARTS_CH_HI:`SARTS_CH_LO];
    next_r.afe.sampleOn = (next_r.st == SARTS_SAMPLE);
    next_r.afe.holdOn = (next_r.st == SARTS_TRIAL) || (next_r.st == SARTS_LATCH);
    next_r.afe.dacCode = next_r.approx;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= SARTS_IDLE;
      r.modeReg <= `SARTS_RST_MODE;
      r.chReg <= `SARTS_RST_CHSEL;
      r.cmpA <= `SARTS_RST_CMP;
      r.cmpB <= `SARTS_RST_CMP;
      r.resA <= `SARTS_RST_RES;
      r.resB <= `SARTS_RST_RES;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign afeCtrl = r.afe;
  assign conversion_done_irq = r.irq;
endmodule

/* bench/sarts_chk_assertions.sv */
// port assertions of the sar trigger sequencer
`timescale 1ns/100ps
module sarts_chk
  import sarts_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sarts_afe_t afeCtrl,
  input wire logic conversion_done_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // lowest set bit marks the bit under trial
  function automatic logic [9:0] low1(input logic [9:0] v);
    return v & (~v + 10'h001);
  endfunction
  sequence sHold;
    $rose(afeCtrl.holdOn);
  endsequence
  sequence sStep;
    afeCtrl.holdOn && $past(afeCtrl.holdOn) && $changed(afeCtrl.dacCode);
  endsequence
  AST_READY: assert property (psel && $rose(penable) |=> pready)
    else $error("late ready");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("stray ready");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("stray error");
  AST_DATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("data outside access");
  AST_SAMPLE: assert property (
    sHold |-> !afeCtrl.sampleOn && $past(afeCtrl.sampleOn, 20))
    else $error("short sample");
  AST_FIRST_TRIAL: assert property (sHold |-> afeCtrl.dacCode == 10'h200)
    else $error("first trial code");
  AST_TRIAL: assert property (
    sStep ##0 !$past(afeCtrl.dacCode[0])
    |-> low1(afeCtrl.dacCode) == low1($past(afeCtrl.dacCode)) >> 1)
    else $error("trial order");
  AST_IRQ_PULSE: assert property (conversion_done_irq |=> !conversion_done_irq)
    else $error("long irq");
  AST_IRQ_HOLD: assert property (conversion_done_irq |-> $past(afeCtrl.holdOn, 2))
    else $error("irq without conversion");
endmodule

bind sarts_top sarts_chk u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .afeCtrl(afeCtrl), .conversion_done_irq(conversion_done_irq));

/* bench/sarts_afe_model.sv */
// behavioural analog side: channel inputs, sample and hold, comparator
`timescale 1ns/100ps
module sarts_afe_model
  import sarts_pkg::*;
(
  input wire logic clk,
  input wire sarts_afe_t afeCtrl,
  input wire logic [15:0][9:0] vin,
  output logic cmpAbove
);
  logic [9:0] held = 10'h155;
  logic tog = 1'b0;
  always @(posedge clk) begin
    tog <= ~tog;
    if (afeCtrl.sampleOn) begin
      held <= vin[afeCtrl.channel];
    end
  end
  // a disabled comparator gives no usable answer, so it toggles
  assign cmpAbove = afeCtrl.cmpEnable ? held >= afeCtrl.dacCode : tog;
endmodule

/* bench/tb.sv */
// self-checking bench of the sar trigger sequencer
`timescale 1ns/100ps
module tb;
  import sarts_pkg::*;
  logic clk = 1'b0;
  logic sys_rst, psel, penable, pwrite, pready, pslverr, cmpAbove, irq, err, b;
  logic [7:0] paddr;
  logic [15:0] tA, tB;
  logic [15:0][9:0] vin;
  logic [31:0] pwdata, prdata, q, irqCnt, res[2];
  int errorCnt, checksDone, cyc, i;
  sarts_afe_t afe;
  always #25 clk = ~clk;
  sarts_top dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timerCountA(tA), .timerCountB(tB),
    .cmpAbove(cmpAbove), .afeCtrl(afe), .conversion_done_irq(irq));
  sarts_afe_model model (.clk(clk), .afeCtrl(afe), .vin(vin), .cmpAbove(cmpAbove));
  task automatic summarize;
    if (errorCnt == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1)
      irqCnt <= irqCnt + 32'h1;
    if (cyc == 5000) begin
      errorCnt++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // a trigger is one cycle of counter equal to the compare value
  task automatic fire(input logic s);
    if (s)
      tB <= 16'h0080;
    else
      tA <= 16'h0040;
    @(posedge clk);
    tA <= 16'h0001;
    tB <= 16'h0001;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    tA = 16'h0001;
    tB = 16'h0001;
    irqCnt = 32'h0;
    res[0] = 32'h0;
    res[1] = 32'h0;
    for (i = 0; i < 16; i++) vin[i] = 10'(i * 59 + 7);
    vin[0] = 10'h3ff;
    vin[5] = 10'h200;
    vin[10] = 10'h1ff;
    vin[15] = 10'h001;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 7; i++) rd(8'(i * 4), 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({q[31:1], err}, 32'h1);
    apb(1'b1, 8'h10, 32'h40);
    apb(1'b1, 8'h14, 32'h80);
    apb(1'b1, 8'h00, 32'h01);
    chk({31'h0, afe.cmpEnable}, 32'h1);
    repeat (20) @(posedge clk);
    for (i = 0; i < 4; i++) begin
      b = i[0];
      apb(1'b1, 8'h04, {26'h0, b, ~b, 4'(i * 5)});
      // time select 3-i makes each step 5*(4-i) cycles long, op mode i
      apb(1'b1, 8'h00, {24'h0, 2'b10, 3'(3 - i), 2'(i), 1'b1});
      chk({30'h0, afe.opMode}, 32'(i));
      fire(~b);
      apb(1'b0, 8'h18, 32'h0);
      chk(q & 32'h3, 32'h2);
      fire(b);
      // sample and ten steps of the selected length end only after this read
      repeat (50 * (4 - i) + 10) @(posedge clk);
      apb(1'b0, 8'h18, 32'h0);
      chk(q & 32'h3, 32'h3);
      repeat (40) @(posedge clk);
      apb(1'b0, 8'h18, 32'h0);
      chk(q & 32'h3, 32'h2);
      res[b] = {22'h0, vin[i * 5]};
      rd(8'h08, res[0]);
      rd(8'h0c, res[1]);
      chk(irqCnt, 32'(i + 1));
    end
    vin[15] <= 10'h2aa;
    fire(1'b1);
    repeat (100) @(posedge clk);
    rd(8'h0c, 32'h2aa);
    // a fresh input shows whether the cut conversion leaks a result
    vin[15] <= 10'h0f0;
    fire(1'b1);
    repeat (30) @(posedge clk);
    apb(1'b0, 8'h18, 32'h0);
    chk(q & 32'h3, 32'h3);
    apb(1'b1, 8'h00, 32'h01);
    repeat (100) @(posedge clk);
    rd(8'h0c, 32'h2aa);
    chk(irqCnt, 32'h5);
    fire(1'b1);
    repeat (100) @(posedge clk);
    chk(irqCnt, 32'h5);
    summarize();
  end
endmodule
